// ==== inc/rxf_pkg.sv ====
package rxf_pkg;
  // ==========================================================================
  // Sizes.
  localparam int DEPTH = 32;
  localparam int CW = 6;
  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_THRESH = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // ==========================================================================
  // Status bit positions.
  localparam int BIT_FULL = 6;
  localparam int BIT_NMTY = 5;
  localparam int BIT_TH = 4;
  localparam int BIT_OVF = 3;
  // ==========================================================================
  // Reset values.
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [5:0] RST_THRESH = 6'h10;
  localparam logic [7:0] RST_MASK = 8'h00;
  // ==========================================================================
  // Operating modes.
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_FIFO = 2'b01,
    MODE_PACKET = 2'b10,
    MODE_RSV = 2'b11
  } rxf_mode_e;
endpackage

// ==== inc/rxf_flag_if.sv ====
`timescale 1ns/1ps
interface rxf_flag_if;
  logic [5:0] level;
  logic [5:0] thresh;
  logic push;
  logic enable;
  logic [7:0] flags;
  modport src (output level, output thresh, output push, output enable, input flags);
  modport gen (input level, input thresh, input push, input enable, output flags);
endinterface

// ==== hw/rxf_flag_gen.sv ====
`timescale 1ns/1ps
module rxf_flag_gen
  import rxf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  rxf_flag_if.gen fi
);
  logic [7:0] flags;
  logic [7:0] next_flags;

  always_comb begin
    next_flags = 8'h00;
    if (fi.enable) begin
      next_flags[BIT_FULL] = (fi.level == CW'(DEPTH));
      next_flags[BIT_NMTY] = (fi.level != 6'h00);
      next_flags[BIT_TH] = (fi.level >= fi.thresh);
      next_flags[BIT_OVF] = fi.push && (fi.level == CW'(DEPTH));
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= 8'h00;
    end else begin
      flags <= next_flags;
    end
  end

  assign fi.flags = flags;

  property p_full;
    @(posedge ref_clk) disable iff (sys_rst)
      (fi.enable && fi.level == CW'(DEPTH)) |=> flags[BIT_FULL];
  endproperty
  a_full: assert property (p_full) else $error("full flag missing");

  property p_direct;
    @(posedge ref_clk) disable iff (sys_rst)
      !fi.enable |=> (flags == 8'h00);
  endproperty
  a_direct: assert property (p_direct) else $error("flags in direct mode");
endmodule

// ==== hw/rxf_status.sv ====
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module rxf_status
  import rxf_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic haddr_sel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_push,
  input wire logic rx_pop,
  output logic irq
);
  if (DEPTH_P != DEPTH) begin : g_depth_check
    $error("only depth 32 supported");
  end

  // ==========================================================================
  // Mode decode.
  // Flags exist only in the buffered modes; direct and the spare code gate them off.
  function automatic logic mode_on(input rxf_mode_e m);
    return (m == MODE_FIFO) || (m == MODE_PACKET);
  endfunction

  // ==========================================================================
  // Bus slave.
  logic ph_wr, ph_rd, next_ph_wr, next_ph_rd;
  logic [7:0] ph_addr, next_ph_addr;
  logic [31:0] rdata, next_rdata;
  rxf_mode_e mode, next_mode;
  logic [5:0] thresh, next_thresh;
  logic [5:0] level, next_level;
  logic [7:0] istat, next_istat, imask, next_imask;
  logic irq_q, next_irq;
  logic [7:0] flags;

  // ==========================================================================
  // Flag generator.
  rxf_flag_if fi ();
  assign fi.level = level;
  assign fi.thresh = thresh;
  assign fi.push = rx_push;
  assign fi.enable = mode_on(mode);
  assign flags = fi.flags;

  rxf_flag_gen u_gen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .fi(fi)
  );

  wire logic take = haddr_sel && hready && htrans[1];
  wire logic rd_stat = take && !hwrite && haddr[7:0] == OFF_IRQ_STAT;

  // ==========================================================================
  // Register file and fill level.
  always_comb begin
    next_ph_wr = take && hwrite;
    next_ph_rd = take && !hwrite;
    next_ph_addr = take ? haddr[7:0] : ph_addr;
    next_mode = mode;
    next_thresh = thresh;
    next_imask = imask;
    next_rdata = 32'h0000_0000;
    if (ph_wr) begin
      unique case (ph_addr)
        OFF_CTRL: begin
          next_mode = rxf_mode_e'(hwdata[1:0]);
        end
        OFF_THRESH: begin
          next_thresh = hwdata[5:0];
        end
        OFF_IRQ_MASK: begin
          next_imask = hwdata[7:0];
        end
        default: begin
          next_mode = mode;
        end
      endcase
    end
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        OFF_STATUS: next_rdata = {24'h0, flags};
        OFF_CTRL: next_rdata = {30'h0, mode};
        OFF_THRESH: next_rdata = {26'h0, thresh};
        OFF_LEVEL: next_rdata = {26'h0, level};
        OFF_IRQ_STAT: next_rdata = {24'h0, istat};
        OFF_IRQ_MASK: next_rdata = {24'h0, imask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_level = level;
    if (rx_push && level != 6'(DEPTH)) begin
      next_level = level + 6'h01;
    end
    if (rx_pop && level != 6'h00) begin
      next_level = next_level - 6'h01;
    end
    // Any flag that is high sets its sticky bit every cycle; the set wins over a read clear.
    next_istat = (rd_stat ? 8'h00 : istat) | flags;
    next_irq = |(next_istat & imask);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
      rdata <= 32'h0000_0000;
      mode <= rxf_mode_e'(RST_MODE);
      thresh <= RST_THRESH;
      imask <= RST_MASK;
      level <= 6'h00;
      istat <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      ph_wr <= next_ph_wr;
      ph_rd <= next_ph_rd;
      ph_addr <= next_ph_addr;
      rdata <= next_rdata;
      mode <= next_mode;
      thresh <= next_thresh;
      imask <= next_imask;
      level <= next_level;
      istat <= next_istat;
      irq_q <= next_irq;
    end
  end

  // ==========================================================================
  // Outputs.
  assign hrdata = rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_q;

  // ==========================================================================
  // Checks.
  property p_nmty;
    @(posedge ref_clk) disable iff (sys_rst)
      (fi.enable && level != 6'h00) |=> flags[BIT_NMTY];
  endproperty
  a_nmty: assert property (p_nmty) else $error("not-empty flag missing");

  property p_th;
    @(posedge ref_clk) disable iff (sys_rst)
      (fi.enable && level < thresh) |=> !flags[BIT_TH];
  endproperty
  a_th: assert property (p_th) else $error("threshold flag stuck");

  property p_ovf;
    @(posedge ref_clk) disable iff (sys_rst)
      (fi.enable && rx_push && level == 6'(DEPTH)) |=> flags[BIT_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun flag missing");

  property p_ro;
    @(posedge ref_clk) disable iff (sys_rst)
      (ph_wr && ph_addr == OFF_STATUS) |=> $stable(mode);
  endproperty
  a_ro: assert property (p_ro) else $error("status write had effect");

  property p_full_clr;
    @(posedge ref_clk) disable iff (sys_rst)
      (level != 6'(DEPTH)) |=> !flags[BIT_FULL];
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("full flag stuck");

  property p_nmty_clr;
    @(posedge ref_clk) disable iff (sys_rst)
      (level == 6'h00) |=> !flags[BIT_NMTY];
  endproperty
  a_nmty_clr: assert property (p_nmty_clr) else $error("not-empty flag stuck");

  property p_th_set;
    @(posedge ref_clk) disable iff (sys_rst)
      (fi.enable && level >= thresh) |=> flags[BIT_TH];
  endproperty
  a_th_set: assert property (p_th_set) else $error("threshold flag missing");

  property p_ovf_clr;
    @(posedge ref_clk) disable iff (sys_rst)
      !(rx_push && level == 6'(DEPTH)) |=> !flags[BIT_OVF];
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overrun flag stuck");

  property p_gate;
    @(posedge ref_clk) disable iff (sys_rst)
      !mode_on(mode) |=> (flags == 8'h00);
  endproperty
  a_gate: assert property (p_gate) else $error("flags outside buffered modes");

  property p_rd_idle;
    @(posedge ref_clk) disable iff (sys_rst)
      !ph_rd |-> (rdata == 32'h0000_0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");

  property p_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      (|flags) |=> ((istat & $past(flags)) == $past(flags));
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit lost a set");

  c_full: cover property (@(posedge ref_clk) flags[BIT_FULL]);
  c_ovf: cover property (@(posedge ref_clk) flags[BIT_OVF]);
  c_irq: cover property (@(posedge ref_clk) irq_q);
  c_th: cover property (@(posedge ref_clk) flags[BIT_TH] && !flags[BIT_FULL]);
  c_spare: cover property (@(posedge ref_clk) mode == MODE_RSV && level != 6'h00);
endmodule

// ==== verification/rxf_byte_src.sv ====
`timescale 1ns/1ps
module rxf_byte_src (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic is_pop,
  input wire logic [6:0] cnt,
  output logic rx_push,
  output logic rx_pop,
  output logic busy
);
  logic [6:0] rem;
  logic pop_r;
  assign busy = rem != 7'h00;
  assign rx_push = busy & ~pop_r;
  assign rx_pop = busy & pop_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem <= 7'h00;
      pop_r <= 1'b0;
    end else if (load) begin
      rem <= cnt;
      pop_r <= is_pop;
    end else if (busy) begin
      rem <= rem - 7'h01;
    end
  end
endmodule

// ==== verification/rxf_status_tb.sv ====
`timescale 1ns/1ps
module rxf_status_tb;
  import rxf_pkg::*;
  logic ref_clk = 0, sys_rst = 1, haddr_sel = 0, hwrite = 0, load = 0, is_pop = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [6:0] cnt = 0;
  logic [5:0] th = 6'h10;
  logic [1:0] mode = 2'h0;
  logic hreadyout, hresp, rx_push, rx_pop, irq, busy;
  logic [31:0] hrdata;
  int fails = 0, check_count = 0, lvl = 0, n;
  rxf_status dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .haddr_sel(haddr_sel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_push(rx_push), .rx_pop(rx_pop),
    .irq(irq));
  rxf_byte_src src (.ref_clk(ref_clk), .sys_rst(sys_rst), .load(load), .is_pop(is_pop),
    .cnt(cnt), .rx_push(rx_push), .rx_pop(rx_pop), .busy(busy));
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] flags();
    logic [31:0] f = 0;
    if (mode == MODE_FIFO || mode == MODE_PACKET) begin
      f[BIT_FULL] = lvl >= DEPTH;
      f[BIT_NMTY] = lvl != 0;
      f[BIT_TH] = lvl >= th;
    end
    return f;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    haddr_sel <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic feed(input int k, input logic p);
    cnt <= k[6:0];
    is_pop <= p;
    load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    do @(posedge ref_clk); while (busy);
    lvl = p ? lvl - k : ((lvl + k > DEPTH) ? DEPTH : lvl + k);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'hc0e75aaf));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rchk(OFF_CTRL, {30'h0, RST_MODE});
    rchk(OFF_THRESH, {26'h0, RST_THRESH});
    rchk(OFF_IRQ_MASK, {24'h0, RST_MASK});
    feed(5, 1'b0);
    rchk(OFF_STATUS, 32'h0);
    rchk(OFF_LEVEL, 32'h5);
    feed(5, 1'b0);
    feed(10, 1'b1);
    for (int m = 1; m < 3; m++) begin
      mode = m[1:0];
      th = 6'($urandom_range(32, 0));
      xfer(1'b1, OFF_CTRL, {30'h0, mode});
      xfer(1'b1, OFF_THRESH, {26'h0, th});
      xfer(1'b1, OFF_IRQ_STAT, 32'h0);
      feed(31, 1'b0);
      rchk(OFF_STATUS, flags());
      feed(1, 1'b0);
      rchk(OFF_STATUS, flags());
      feed(1, 1'b0);
      xfer(1'b0, OFF_IRQ_STAT, 32'h0);
      chk(rd[BIT_OVF], 1'b1);
      xfer(1'b1, OFF_STATUS, 32'h0);
      rchk(OFF_STATUS, flags());
      while (lvl > 0) begin
        n = (lvl == DEPTH) ? 1 : $urandom_range(lvl, 1);
        feed(n, 1'b1);
        rchk(OFF_STATUS, flags());
      end
    end
    xfer(1'b1, OFF_IRQ_MASK, 32'h1 << BIT_NMTY);
    xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    feed(1, 1'b0);
    chk(irq, 1'b1);
    feed(1, 1'b1);
    xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    xfer(1'b1, OFF_CTRL, 32'h3);
    feed(2, 1'b0);
    rchk(OFF_STATUS, 32'h0);
    rchk(OFF_LEVEL, 32'h2);
    rchk(8'h40, 32'h0);
    conclude();
  end
endmodule
